// file: hdl/dtc_defs.vh
// Purpose: shared constants of the dual timer/counter
// Assumes: included by bare name from every design file of the block
// Notes:   definitions only
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// clock and machine-cycle timing
`define DTC_CLK_PERIOD_NS   50
`define DTC_PHASES_PER_MC   4
`define DTC_PH_THREE        2'h2
`define DTC_PH_FOUR         2'h3
`define DTC_SLOW_DIV        12
`define DTC_FAST_DIV        4
`define DTC_SLOW_MC         (`DTC_SLOW_DIV / `DTC_FAST_DIV)
`define DTC_SLOW_MC_LAST    2'h2

// timer_mode_reg fields, per timer nibble
`define DTC_T0_NIB_LSB      0
`define DTC_T1_NIB_LSB      4
`define DTC_MODE_LO_BIT     0
`define DTC_MODE_HI_BIT     1
`define DTC_CNT_SEL_BIT     2
`define DTC_GATE_SEL_BIT    3

// operating modes {mode_sel_hi, mode_sel_lo}
`define DTC_MODE_13BIT      2'h0
`define DTC_MODE_16BIT      2'h1
`define DTC_MODE_RELOAD     2'h2
`define DTC_MODE_SPLIT      2'h3

// count byte write strobes
`define DTC_WR_T0_LOW       0
`define DTC_WR_T0_HIGH      1
`define DTC_WR_T1_LOW       2
`define DTC_WR_T1_HIGH      3

// reset values
`define DTC_COUNT_RST       8'h00
`define DTC_FLAG_RST        1'b0
`define DTC_BYTE_ONES       8'hFF

`endif

// file: hdl/dtc_phase_gen.v
// Purpose: machine-cycle phase sequencer and slow-rate divider
// Assumes: four clocks per machine cycle, one phase per clock
// Notes:   slow tick marks phase three of every third machine cycle
`timescale 1ns/100ps
`include "dtc_defs.vh"

module dtc_phase_gen (
  input  wire       clk,
  input  wire       rst_n,
  output wire       phase_three,
  output wire       phase_four,
  output wire       slow_tick
);

  reg  [1:0] phase;
  reg  [1:0] mc_cnt;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase  <= 2'h0;
      mc_cnt <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      if (phase == `DTC_PH_FOUR) begin
        if (mc_cnt == `DTC_SLOW_MC_LAST)
          mc_cnt <= 2'h0;
        else
          mc_cnt <= mc_cnt + 2'h1;
      end
    end
  end

  assign phase_three = (phase == `DTC_PH_THREE);
  assign phase_four  = (phase == `DTC_PH_FOUR);
  assign slow_tick   = phase_three && (mc_cnt == 2'h0);

endmodule

// file: hdl/dtc_pin_sampler.v
// Purpose: synchronise external pins and detect falling edges per machine cycle
// Assumes: sample is the one-clock phase-four strobe
// Notes:   fall holds for a whole machine cycle, so it is seen by one phase three
`timescale 1ns/100ps
`include "dtc_defs.vh"

module dtc_pin_sampler #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] pins,
  input  wire         sample,
  output wire [W-1:0] level,
  output reg  [W-1:0] fall
);

  reg  [W-1:0] sync_a;
  reg  [W-1:0] sync_b;
  reg  [W-1:0] last;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= {W{1'b0}};
      sync_b <= {W{1'b0}};
      last   <= {W{1'b0}};
      fall   <= {W{1'b0}};
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      if (sample) begin
        last <= sync_b;
        fall <= last & ~sync_b;
      end
    end
  end

  assign level = sync_b;

endmodule

// file: hdl/dtc_top.v
// Purpose: two 16-bit timer/counters with four modes and overflow flags
// Assumes: 20 MHz CLK; control bits arrive as plain ports from the CPU side
// Notes:   machine cycle is four clocks; writes to count bytes win over counting
//
// Functional notes
// - each timer is a high byte and a low byte, separately writable
// - per timer: counter select picks clock or pin, two bits pick mode
// - count steps land only at machine-cycle phase three; byte writes land on any clock
// - clock counting runs at 1/12 clock, or 1/4 when rate select is 1
// - count pin sampled at phase four; high then low counts next phase three
// - timer 0 counts count_pin_0, timer 1 counts count_pin_1
// - mode 0: 13 bits, high byte plus low five bits of low byte
// - outside split mode, count only when run set and gate select clear or gate pin high
// - mode 0 wrap to zero sets the overflow flag
// - mode 1 equals mode 0 but uses all 16 bits
// - mode 2: low byte counts, reloads from high byte on wrap, sets flag
// - mode 2 still obeys run and gate, clock or pin source
// - split mode: timer 0 low byte uses all timer 0 controls and flag
// - split mode: timer 0 high byte counts clocks, runs on timer 1 run
// - timer 1 in mode 3 holds its count
// - while split, timer 1 runs modes 0-2 without run bit or flag
// - overflow flags clear on entry to their service routine
// - software may set or clear each overflow flag directly
`timescale 1ns/100ps
`include "dtc_defs.vh"

module dtc_top (
  input  wire       CLK,
  input  wire       RESET_N,
  input  wire [7:0] TIMER_MODE_REG,
  input  wire       TIMER0_RUN,
  input  wire       TIMER1_RUN,
  input  wire       TIMER0_RATE_SEL,
  input  wire       TIMER1_RATE_SEL,
  input  wire       COUNT_PIN_0,
  input  wire       COUNT_PIN_1,
  input  wire       EXT_IRQ0_GATE_PIN,
  input  wire       EXT_IRQ1_GATE_PIN,
  input  wire [3:0] CNT_WR_SEL,
  input  wire [7:0] CNT_WR_DATA,
  input  wire [1:0] FLAG_WR,
  input  wire [1:0] FLAG_WR_DATA,
  input  wire [1:0] ISR_ENTRY,
  output reg  [7:0] TIMER0_COUNT_LOW,
  output reg  [7:0] TIMER0_COUNT_HIGH,
  output reg  [7:0] TIMER1_COUNT_LOW,
  output reg  [7:0] TIMER1_COUNT_HIGH,
  output reg        TIMER0_OVERFLOW_FLAG,
  output reg        TIMER1_OVERFLOW_FLAG,
  output reg        TIMER1_BAUD_TICK,
  output wire       PHASE_THREE,
  output wire       PHASE_FOUR
);

  wire        slow_tick;
  wire [3:0]  pin_level;
  wire [3:0]  pin_fall;

  wire [3:0]  t0_nib;
  wire [3:0]  t1_nib;
  wire [1:0]  t0_mode;
  wire [1:0]  t1_mode;
  wire        t0_cnt_sel;
  wire        t1_cnt_sel;
  wire        t0_gate_sel;
  wire        t1_gate_sel;
  wire        split;

  wire        t0_clk_inc;
  wire        t1_clk_inc;
  wire        t0_src;
  wire        t1_src;
  wire        t0_gate_ok;
  wire        t1_gate_ok;
  wire        t0_inc;
  wire        t1_inc;
  wire        t0h_inc;

  reg  [16:0] next_t0;
  reg  [16:0] next_t1;
  reg  [8:0]  next_t0h_split;
  reg  [8:0]  next_t0l_split;
  wire        t0_ovf;
  wire        t1_ovf;
  wire        t0h_ovf;
  wire        tf0_set;
  wire        tf1_set;

  // one count step for one timer: returns {overflow, high, low}
  function [16:0] count_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    input       inc;
    reg   [13:0] sum13;
    reg   [16:0] sum16;
    reg   [8:0]  sum8;
    begin
      sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      sum16 = {1'b0, hi, lo} + 17'h00001;
      sum8  = {1'b0, lo} + 9'h001;
      count_step = {1'b0, hi, lo};
      if (inc) begin
        case (mode)
          `DTC_MODE_13BIT: begin
            // upper three low-byte bits ride along untouched
            count_step = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]};
          end
          `DTC_MODE_16BIT: begin
            count_step = sum16;
          end
          `DTC_MODE_RELOAD: begin
            if (sum8[8])
              count_step = {1'b1, hi, hi};
            else
              count_step = {1'b0, hi, sum8[7:0]};
          end
          default: begin
            count_step = {1'b0, hi, lo};
          end
        endcase
      end
    end
  endfunction

  dtc_phase_gen u_phase (
    .clk         (CLK),
    .rst_n       (RESET_N),
    .phase_three (PHASE_THREE),
    .phase_four  (PHASE_FOUR),
    .slow_tick   (slow_tick)
  );

  // bit order: count_pin_0, count_pin_1, gate 0, gate 1
  dtc_pin_sampler #(
    .W (4)
  ) u_pins (
    .clk    (CLK),
    .rst_n  (RESET_N),
    .pins   ({EXT_IRQ1_GATE_PIN, EXT_IRQ0_GATE_PIN, COUNT_PIN_1, COUNT_PIN_0}),
    .sample (PHASE_FOUR),
    .level  (pin_level),
    .fall   (pin_fall)
  );

  assign t0_nib      = TIMER_MODE_REG[`DTC_T0_NIB_LSB +: 4];
  assign t1_nib      = TIMER_MODE_REG[`DTC_T1_NIB_LSB +: 4];
  assign t0_mode     = {t0_nib[`DTC_MODE_HI_BIT], t0_nib[`DTC_MODE_LO_BIT]};
  assign t1_mode     = {t1_nib[`DTC_MODE_HI_BIT], t1_nib[`DTC_MODE_LO_BIT]};
  assign t0_cnt_sel  = t0_nib[`DTC_CNT_SEL_BIT];
  assign t1_cnt_sel  = t1_nib[`DTC_CNT_SEL_BIT];
  assign t0_gate_sel = t0_nib[`DTC_GATE_SEL_BIT];
  assign t1_gate_sel = t1_nib[`DTC_GATE_SEL_BIT];
  assign split       = (t0_mode == `DTC_MODE_SPLIT);

  // clock-cycle ticks land on phase three only
  assign t0_clk_inc = TIMER0_RATE_SEL ? PHASE_THREE : slow_tick;
  assign t1_clk_inc = TIMER1_RATE_SEL ? PHASE_THREE : slow_tick;

  // pin falls are held a machine cycle, consumed at phase three
  assign t0_src = t0_cnt_sel ? (pin_fall[0] & PHASE_THREE) : t0_clk_inc;
  assign t1_src = t1_cnt_sel ? (pin_fall[1] & PHASE_THREE) : t1_clk_inc;

  assign t0_gate_ok = ~t0_gate_sel | pin_level[2];
  assign t1_gate_ok = ~t1_gate_sel | pin_level[3];

  assign t0_inc = TIMER0_RUN & t0_gate_ok & t0_src;

  // while split, timer 1 loses its run bit and free-runs under its gate
  assign t1_inc = (split ? 1'b1 : TIMER1_RUN) & t1_gate_ok & t1_src;

  // split high byte: clock counter at timer 0 rate, run by timer 1 run bit
  assign t0h_inc = split & TIMER1_RUN & t0_clk_inc;

  always @* begin
    next_t0        = count_step(t0_mode, TIMER0_COUNT_HIGH, TIMER0_COUNT_LOW, t0_inc);
    next_t1        = count_step(t1_mode, TIMER1_COUNT_HIGH, TIMER1_COUNT_LOW, t1_inc);
    next_t0l_split = {1'b0, TIMER0_COUNT_LOW};
    next_t0h_split = {1'b0, TIMER0_COUNT_HIGH};
    if (t0_inc)
      next_t0l_split = {1'b0, TIMER0_COUNT_LOW} + 9'h001;
    if (t0h_inc)
      next_t0h_split = {1'b0, TIMER0_COUNT_HIGH} + 9'h001;
  end

  assign t0_ovf  = split ? next_t0l_split[8] : next_t0[16];
  assign t0h_ovf = next_t0h_split[8];
  assign t1_ovf  = next_t1[16];

  // timer 1 overflow reaches its flag only when it owns it
  assign tf0_set = t0_ovf;
  assign tf1_set = split ? t0h_ovf : t1_ovf;

  // timer 0 count bytes; software writes win over a same-cycle step
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER0_COUNT_LOW  <= `DTC_COUNT_RST;
      TIMER0_COUNT_HIGH <= `DTC_COUNT_RST;
    end else begin
      if (CNT_WR_SEL[`DTC_WR_T0_LOW])
        TIMER0_COUNT_LOW <= CNT_WR_DATA;
      else if (split)
        TIMER0_COUNT_LOW <= next_t0l_split[7:0];
      else
        TIMER0_COUNT_LOW <= next_t0[7:0];
      if (CNT_WR_SEL[`DTC_WR_T0_HIGH])
        TIMER0_COUNT_HIGH <= CNT_WR_DATA;
      else if (split)
        TIMER0_COUNT_HIGH <= next_t0h_split[7:0];
      else
        TIMER0_COUNT_HIGH <= next_t0[15:8];
    end
  end

  // timer 1 count bytes; mode 3 freezes them inside count_step
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER1_COUNT_LOW  <= `DTC_COUNT_RST;
      TIMER1_COUNT_HIGH <= `DTC_COUNT_RST;
    end else begin
      if (CNT_WR_SEL[`DTC_WR_T1_LOW])
        TIMER1_COUNT_LOW <= CNT_WR_DATA;
      else
        TIMER1_COUNT_LOW <= next_t1[7:0];
      if (CNT_WR_SEL[`DTC_WR_T1_HIGH])
        TIMER1_COUNT_HIGH <= CNT_WR_DATA;
      else
        TIMER1_COUNT_HIGH <= next_t1[15:8];
    end
  end

  // overflow flags: a hardware set beats any clear in the same cycle
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER0_OVERFLOW_FLAG <= `DTC_FLAG_RST;
      TIMER1_OVERFLOW_FLAG <= `DTC_FLAG_RST;
    end else begin
      if (tf0_set)
        TIMER0_OVERFLOW_FLAG <= 1'b1;
      else if (FLAG_WR[0])
        TIMER0_OVERFLOW_FLAG <= FLAG_WR_DATA[0];
      else if (ISR_ENTRY[0])
        TIMER0_OVERFLOW_FLAG <= 1'b0;
      if (tf1_set)
        TIMER1_OVERFLOW_FLAG <= 1'b1;
      else if (FLAG_WR[1])
        TIMER1_OVERFLOW_FLAG <= FLAG_WR_DATA[1];
      else if (ISR_ENTRY[1])
        TIMER1_OVERFLOW_FLAG <= 1'b0;
    end
  end

  // baud source keeps running from timer 1 even while split
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N)
      TIMER1_BAUD_TICK <= 1'b0;
    else
      TIMER1_BAUD_TICK <= t1_ovf;
  end

endmodule

// file: tb/dtc_pin_src.sv
// Purpose: far-side source for the count and gate pins
// Assumes: pins idle high through pull-ups; gate pins driven
// Notes:   each level held HOLD clocks, well over one machine cycle
`timescale 1ns/100ps
module dtc_pin_src #(
  parameter int HOLD = 12
) (
  input  wire        clk,
  output logic [1:0] count_pin,
  output logic [1:0] gate_pin
);
  initial begin
    count_pin = 2'h3;
    gate_pin  = 2'h0;
  end
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      count_pin[idx] = 1'b0;
      repeat (HOLD) @(negedge clk);
      count_pin[idx] = 1'b1;
      repeat (HOLD) @(negedge clk);
    end
  endtask
endmodule

// file: tb/dtc_top_chk_chk.sv
// Purpose: port-level checks of the dual timer/counter
// Assumes: bound to dtc_top, single clock domain
// Notes:   timer 0 carries most checks; timer 1 shares the logic
`timescale 1ns/100ps
module dtc_top_chk (
  input wire       CLK,
  input wire       RESET_N,
  input wire [7:0] TIMER_MODE_REG,
  input wire       TIMER0_RUN,
  input wire [3:0] CNT_WR_SEL,
  input wire [7:0] CNT_WR_DATA,
  input wire [1:0] FLAG_WR,
  input wire [1:0] FLAG_WR_DATA,
  input wire [1:0] ISR_ENTRY,
  input wire [7:0] TIMER0_COUNT_LOW,
  input wire [7:0] TIMER0_COUNT_HIGH,
  input wire [7:0] TIMER1_COUNT_LOW,
  input wire [7:0] TIMER1_COUNT_HIGH,
  input wire       TIMER0_OVERFLOW_FLAG,
  input wire       TIMER1_OVERFLOW_FLAG,
  input wire       PHASE_THREE,
  input wire       PHASE_FOUR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire [15:0] t0 = {TIMER0_COUNT_HIGH, TIMER0_COUNT_LOW};
  wire        nowr0 = (CNT_WR_SEL[1:0] == 2'h0);
  sequence wrap16_s;
    (t0 == 16'hFFFF && TIMER_MODE_REG[1:0] == 2'h1 && nowr0) ##1 (t0 == 16'h0000);
  endsequence
  sequence wrap13_s;
    ({t0[15:8], t0[4:0]} == 13'h1FFF && TIMER_MODE_REG[1:0] == 2'h0 && nowr0)
      ##1 ({t0[15:8], t0[4:0]} == 13'h0000);
  endsequence
  sequence reload_s;
    (TIMER_MODE_REG[1:0] == 2'h2 && TIMER0_COUNT_LOW == 8'hFF && nowr0)
      ##1 (TIMER0_COUNT_LOW != 8'hFF);
  endsequence
  phase_order_a: assert property (PHASE_FOUR |=> !PHASE_THREE [*2] ##1 PHASE_THREE)
    else $error("phase order broken");
  count_phase_a: assert property ($changed(TIMER0_COUNT_HIGH) |-> $past(PHASE_THREE) || $past(CNT_WR_SEL[1]))
    else $error("count moved off phase three");
  run_hold_a: assert property (!TIMER0_RUN && !CNT_WR_SEL[0] |=> $stable(TIMER0_COUNT_LOW))
    else $error("low byte moved while stopped");
  wrap13_flag_a: assert property (wrap13_s |-> TIMER0_OVERFLOW_FLAG)
    else $error("13-bit wrap without flag");
  wrap16_flag_a: assert property (wrap16_s |-> TIMER0_OVERFLOW_FLAG)
    else $error("16-bit wrap without flag");
  reload_value_a: assert property (reload_s |-> TIMER0_COUNT_LOW == $past(TIMER0_COUNT_HIGH) && TIMER0_OVERFLOW_FLAG)
    else $error("reload wrong");
  timer1_freeze_a: assert property (TIMER_MODE_REG[5:4] == 2'h3 && CNT_WR_SEL[3:2] == 2'h0 |=> $stable({TIMER1_COUNT_HIGH, TIMER1_COUNT_LOW}))
    else $error("timer 1 moved in mode 3");
  isr_clear_a: assert property (ISR_ENTRY[0] && !FLAG_WR[0] && !TIMER0_RUN |=> !TIMER0_OVERFLOW_FLAG)
    else $error("flag 0 kept after service entry");
  sw_set_a: assert property (FLAG_WR[1] && FLAG_WR_DATA[1] |=> TIMER1_OVERFLOW_FLAG)
    else $error("flag 1 not set by write");
  low_write_a: assert property (CNT_WR_SEL[0] |=> TIMER0_COUNT_LOW == $past(CNT_WR_DATA))
    else $error("low byte write lost");
endmodule
bind dtc_top dtc_top_chk dtc_top_chk_inst (
  .CLK(CLK), .RESET_N(RESET_N), .TIMER_MODE_REG(TIMER_MODE_REG), .TIMER0_RUN(TIMER0_RUN),
  .CNT_WR_SEL(CNT_WR_SEL), .CNT_WR_DATA(CNT_WR_DATA), .FLAG_WR(FLAG_WR),
  .FLAG_WR_DATA(FLAG_WR_DATA), .ISR_ENTRY(ISR_ENTRY), .TIMER0_COUNT_LOW(TIMER0_COUNT_LOW),
  .TIMER0_COUNT_HIGH(TIMER0_COUNT_HIGH), .TIMER1_COUNT_LOW(TIMER1_COUNT_LOW),
  .TIMER1_COUNT_HIGH(TIMER1_COUNT_HIGH), .TIMER0_OVERFLOW_FLAG(TIMER0_OVERFLOW_FLAG),
  .TIMER1_OVERFLOW_FLAG(TIMER1_OVERFLOW_FLAG), .PHASE_THREE(PHASE_THREE), .PHASE_FOUR(PHASE_FOUR));

// file: tb/tb_dual_timer_counter.sv
// Purpose: self-checking bench of the dual timer/counter
// Assumes: inputs change at the falling edge, outputs read there
// Notes:   run windows are whole clock counts, so step counts are exact
`timescale 1ns/100ps
module tb_dual_timer_counter;
  typedef struct {
    logic [1:0] mode; int t; logic rate; logic [7:0] hi, lo; int clks; logic [15:0] ecnt; logic eflag;
  } dtc_row_t;
  logic       clk = 1'b0, rst_n = 1'b0;
  logic [7:0] mode_reg = 8'h00, wr_data = 8'h00;
  logic [3:0] wr_sel = 4'h0;
  logic [1:0] run = 2'h0, rate = 2'h0, flag_wr = 2'h0, flag_data = 2'h0, isr = 2'h0;
  wire  [1:0] count_pin, gate_pin, flag;
  wire  [7:0] t0l, t0h, t1l, t1h;
  int         fail_count = 0, tests_run = 0;
  wire        baud;
  int         baud_cnt = 0, baud_mark = 0;
  dtc_row_t   rows [5] = '{
    '{2'h0, 0, 1'b1, 8'hFF, 8'hFE, 12, 16'h00E1, 1'b1},  // 13-bit wrap, upper bits kept
    '{2'h1, 0, 1'b1, 8'hFF, 8'hFE, 12, 16'h0001, 1'b1},
    '{2'h2, 0, 1'b1, 8'h80, 8'hFE, 12, 16'h8081, 1'b1},
    '{2'h1, 0, 1'b0, 8'h12, 8'h34, 48, 16'h1238, 1'b0},  // slow rate: 4 steps in 48 clocks
    '{2'h2, 1, 1'b1, 8'h05, 8'hFF, 12, 16'h0507, 1'b1}};
  always #25 clk = ~clk;
  always @(posedge clk) if (baud === 1'b1) baud_cnt <= baud_cnt + 1;
  dtc_pin_src dtc_pin_src_inst (.clk(clk), .count_pin(count_pin), .gate_pin(gate_pin));
  dtc_top dtc_top_inst (
    .CLK(clk), .RESET_N(rst_n), .TIMER_MODE_REG(mode_reg), .TIMER0_RUN(run[0]),
    .TIMER1_RUN(run[1]), .TIMER0_RATE_SEL(rate[0]), .TIMER1_RATE_SEL(rate[1]),
    .COUNT_PIN_0(count_pin[0]), .COUNT_PIN_1(count_pin[1]), .EXT_IRQ0_GATE_PIN(gate_pin[0]),
    .EXT_IRQ1_GATE_PIN(gate_pin[1]), .CNT_WR_SEL(wr_sel), .CNT_WR_DATA(wr_data),
    .FLAG_WR(flag_wr), .FLAG_WR_DATA(flag_data), .ISR_ENTRY(isr), .TIMER0_COUNT_LOW(t0l),
    .TIMER0_COUNT_HIGH(t0h), .TIMER1_COUNT_LOW(t1l), .TIMER1_COUNT_HIGH(t1h),
    .TIMER0_OVERFLOW_FLAG(flag[0]), .TIMER1_OVERFLOW_FLAG(flag[1]), .TIMER1_BAUD_TICK(baud),
    .PHASE_THREE(), .PHASE_FOUR());
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    wr_sel = sel;
    wr_data = d;
    tick(1);
  endtask
  // strobe held between back-to-back writes, dropped once after the last
  task automatic load(input logic [15:0] c0, input logic [15:0] c1);
    wr(4'h2, c0[15:8]); wr(4'h1, c0[7:0]); wr(4'h8, c1[15:8]); wr(4'h4, c1[7:0]);
    wr_sel = 4'h0;
    flag_wr = 2'h3; flag_data = 2'h0; tick(1); flag_wr = 2'h0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    tick(2);
    chk("reset counts", 16'h0000, {t0h, t0l});
    rst_n = 1'b1;
    foreach (rows[i]) begin
      mode_reg = 8'h00; mode_reg[rows[i].t*4 +: 2] = rows[i].mode; rate[rows[i].t] = rows[i].rate;
      load({rows[i].hi, rows[i].lo}, {rows[i].hi, rows[i].lo});
      run[rows[i].t] = 1'b1; tick(rows[i].clks); run = 2'h0; tick(2);
      chk("row count", rows[i].ecnt, rows[i].t ? {t1h, t1l} : {t0h, t0l});
      chk("row flag", {15'h0, rows[i].eflag}, {15'h0, flag[rows[i].t]});
    end
    rate = 2'h3; mode_reg = 8'h09; load(16'h0000, 16'h0000); tick(4);
    run = 2'h1; tick(12); run = 2'h0;
    chk("gate closed", 16'h0000, {t0h, t0l});
    force_gate_open();
    run = 2'h1; tick(12); run = 2'h0; tick(2);
    chk("gate open", 16'h0003, {t0h, t0l});
    mode_reg = 8'h55; load(16'h0000, 16'h0000); run = 2'h3;
    dtc_pin_src_inst.pulse(0, 3); tick(8);
    chk("pin 0 to t0", 16'h0003, {t0h, t0l});
    dtc_pin_src_inst.pulse(1, 2); tick(8); run = 2'h0;
    chk("pin 1 to t1", 16'h0002, {t1h, t1l});
    chk("t0 untouched", 16'h0003, {t0h, t0l});
    mode_reg = 8'h23; load(16'hFE10, 16'h00FE); baud_mark = baud_cnt;
    run = 2'h2; tick(8); run = 2'h0;
    chk("baud tick", 16'h0001, 16'(baud_cnt - baud_mark));
    chk("split t0", 16'h0010, {t0h, t0l});
    chk("split t1", 16'h0000, {t1h, t1l});
    chk("split flags", 16'h0002, {14'h0, flag});
    run = 2'h1; tick(8); run = 2'h0;
    chk("split run", 16'h0012, {t0h, t0l});
    chk("t1 runs free", 16'h0002, {t1h, t1l});
    mode_reg = 8'h30; run = 2'h3; tick(12); run = 2'h0;
    chk("t1 frozen", 16'h0002, {t1h, t1l});
    for (int i = 0; i < 2; i++) begin
      flag_wr[i] = 1'b1; flag_data[i] = 1'b1; tick(1); flag_wr = 2'h0;
      chk("sw set", 16'h0001, {15'h0, flag[i]});
      isr[i] = 1'b1; tick(1); isr = 2'h0;
      chk("isr clear", 16'h0000, {15'h0, flag[i]});
    end
    run = 2'h3; tick(5); rst_n = 1'b0; tick(2);
    chk("second reset", 16'h0000, {t0h, t0l, t1h, t1l} == 32'h0 ? 16'h0 : 16'h1);
    conclude();
  end
  task automatic force_gate_open;
    dtc_pin_src_inst.gate_pin[0] = 1'b1;
    tick(4);
  endtask
endmodule
